// ---- rtl/rpu_pkg.sv ----
// shared types, constants and helpers of the region protection unit
package rpu_pkg;

  localparam int          RPU_REGIONS    = 8;
  localparam int          RPU_SUB_BITS   = 3;
  localparam logic [31:0] RPU_CODE_LAST  = 32'h1FFF_FFFF;
  localparam logic [31:0] RPU_SYS_FIRST  = 32'h2000_0000;
  localparam logic [4:0]  RPU_MIN_SIZE   = 5'h08;
  localparam logic        RPU_ENABLE_RST = 1'b0;
  localparam logic        RPU_PRIVDEF_RST = 1'b0;

  typedef enum logic [1:0] {
    RPU_FETCH = 2'b00,
    RPU_READ  = 2'b01,
    RPU_WRITE = 2'b10
  } rpu_kind_t;

  // unlisted codes deny everything
  typedef enum logic [2:0] {
    RPU_AP_NONE            = 3'b000,
    RPU_AP_PRIV_RW         = 3'b001,
    RPU_AP_PRIV_RW_USER_RO = 3'b010,
    RPU_AP_RW              = 3'b011,
    RPU_AP_PRIV_RO         = 3'b101,
    RPU_AP_RO              = 3'b110
  } rpu_ap_t;

  // size is log2 of the region length in bytes
  typedef struct packed {
    logic        en;
    logic [31:0] base;
    logic [4:0]  size;
    logic [7:0]  sub_off;
    rpu_ap_t     ap;
    logic        xn;
  } rpu_region_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    rpu_kind_t   kind;
    logic        priv;
  } rpu_req_t;

  typedef struct packed {
    logic      no_region;
    logic      denied;
    logic      wrong_bus;
    logic      code_port;
    rpu_kind_t kind;
    logic      priv;
  } rpu_fault_t;

  localparam rpu_region_t RPU_REGION_RST = '0;
  localparam rpu_fault_t  RPU_FAULT_RST  = '0;

  function automatic logic [31:0] rpu_size_mask(input logic [4:0] size);
    rpu_size_mask = ~((32'h0000_0001 << size) - 32'h0000_0001);
  endfunction : rpu_size_mask

  function automatic logic rpu_perm_ok(input rpu_ap_t ap, input logic xn,
                                       input rpu_kind_t kind,
                                       input logic priv);
    logic wr;
    wr = (kind == RPU_WRITE);
    unique case (ap)
      RPU_AP_PRIV_RW:         rpu_perm_ok = priv;
      RPU_AP_PRIV_RW_USER_RO: rpu_perm_ok = priv || !wr;
      RPU_AP_RW:              rpu_perm_ok = 1'b1;
      RPU_AP_PRIV_RO:         rpu_perm_ok = priv && !wr;
      RPU_AP_RO:              rpu_perm_ok = !wr;
      default:                rpu_perm_ok = 1'b0;
    endcase
    if (kind == RPU_FETCH && xn) begin
      rpu_perm_ok = 1'b0;
    end
  endfunction : rpu_perm_ok

endpackage : rpu_pkg

// ---- rtl/rpu_region_match.sv ----
// one region compared against one address
`timescale 1ns/10ps
`default_nettype none
module rpu_region_match
  import rpu_pkg::*;
(
  input  wire rpu_region_t region,
  input  wire rpu_req_t    req,
  output logic             hit,
  output logic             ok
);
  logic [31:0] mask;
  logic [31:0] shifted;
  logic [2:0]  sub_idx;

  // the top three bits inside the region pick one of eight subregions
  always_comb begin
    mask    = rpu_size_mask(region.size);
    shifted = req.addr >> (region.size - 5'd3);
    sub_idx = shifted[2:0];
    // a disabled subregion leaves the address to lower regions
    hit = region.en && (region.size >= RPU_MIN_SIZE)
          && ((req.addr & mask) == (region.base & mask))
          && !region.sub_off[sub_idx];
    ok  = rpu_perm_ok(region.ap, region.xn, req.kind, req.priv);
  end
endmodule : rpu_region_match
`default_nettype wire

// ---- rtl/rpu_top.sv ----
// region protection unit checking the primary processor's two buses
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - eight programmable regions check every code and system bus access
// - each region splits into eight subregions
// - disallowed or uncovered access blocks and faults, except privileged uncovered access when privdef is set
// - read-only region rejects writes
// - no-access region rejects everything
// - permissions differ between privileged and user
// - secondary processor accesses pass unchecked
// - configuration only through private peripheral port
module rpu_top
  import rpu_pkg::*;
#(
  parameter int NREG = RPU_REGIONS
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire rpu_req_t    code_req,
  input  wire rpu_req_t    sys_req,
  input  wire logic        sec_valid,
  input  wire logic        ppb_region_we,
  input  wire logic [2:0]  ppb_region_idx,
  input  wire rpu_region_t ppb_region,
  input  wire logic        ppb_ctrl_we,
  input  wire logic        ppb_enable,
  input  wire logic        ppb_privdef,
  output logic             code_done,
  output logic             code_ok,
  output logic             sys_done,
  output logic             sys_ok,
  output logic             sec_done,
  output logic             fault,
  output logic [31:0]      fault_addr,
  output rpu_fault_t       fault_info,
  output logic             unit_enabled
);

  rpu_region_t        regions      [NREG];
  rpu_region_t        next_regions [NREG];
  logic               privdef;
  logic               next_privdef;
  logic               next_enabled;
  rpu_req_t           req          [2];
  logic [NREG-1:0]    hit          [2];
  logic [NREG-1:0]    okv          [2];
  logic               win_hit      [2];
  logic [2:0]         win_idx      [2];
  logic               allow        [2];
  logic               bad_bus      [2];
  logic               next_code_done;
  logic               next_code_ok;
  logic               next_sys_done;
  logic               next_sys_ok;
  logic               next_sec_done;
  logic               next_fault;
  logic [31:0]        next_fault_addr;
  rpu_fault_t         next_fault_info;

  assign req[0] = code_req;
  assign req[1] = sys_req;

  // one comparator per region and bus; both buses checked in parallel
  for (genvar p = 0; p < 2; p++) begin : g_port
    for (genvar r = 0; r < NREG; r++) begin : g_reg
      rpu_region_match u_match (
        .region (regions[r]),
        .req    (req[p]),
        .hit    (hit[p][r]),
        .ok     (okv[p][r])
      );
    end
  end

  // configuration registers, written only from the private port
  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      next_regions[r] = regions[r];
    end
    next_privdef = privdef;
    next_enabled = unit_enabled;
    if (ppb_region_we) begin
      next_regions[ppb_region_idx] = ppb_region;
    end
    if (ppb_ctrl_we) begin
      next_enabled = ppb_enable;
      next_privdef = ppb_privdef;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int r = 0; r < NREG; r++) begin
        regions[r] <= RPU_REGION_RST;
      end
      privdef      <= RPU_PRIVDEF_RST;
      unit_enabled <= RPU_ENABLE_RST;
    end else begin
      for (int r = 0; r < NREG; r++) begin
        regions[r] <= next_regions[r];
      end
      privdef      <= next_privdef;
      unit_enabled <= next_enabled;
    end
  end

  // decision per bus; later regions overwrite earlier ones on overlap
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      win_hit[p] = 1'b0;
      win_idx[p] = 3'h0;
      for (int r = 0; r < NREG; r++) begin
        if (hit[p][r]) begin
          win_hit[p] = 1'b1;
          win_idx[p] = r[2:0];
        end
      end
      // the core routes by address; a stray one is a bus fault
      bad_bus[p] = (p == 0) ? (req[p].addr > RPU_CODE_LAST)
                            : (req[p].addr < RPU_SYS_FIRST);
      if (!unit_enabled) begin
        allow[p] = 1'b1;
      end else if (win_hit[p]) begin
        allow[p] = okv[p][win_idx[p]];
      end else begin
        allow[p] = req[p].priv && privdef;
      end
      allow[p] = allow[p] && !bad_bus[p];
    end
  end

  // answers and fault record; the code bus wins when both fault together
  always_comb begin
    next_code_done  = code_req.valid;
    next_code_ok    = code_req.valid && allow[0];
    next_sys_done   = sys_req.valid;
    next_sys_ok     = sys_req.valid && allow[1];
    next_sec_done   = sec_valid; // no checking on this processor
    next_fault      = 1'b0;
    next_fault_addr = fault_addr;
    next_fault_info = fault_info;
    for (int p = 1; p >= 0; p--) begin
      if (req[p].valid && !allow[p]) begin
        next_fault                = 1'b1;
        next_fault_addr           = req[p].addr;
        next_fault_info.no_region = !win_hit[p] && !bad_bus[p];
        next_fault_info.denied    = win_hit[p] && !bad_bus[p];
        next_fault_info.wrong_bus = bad_bus[p];
        next_fault_info.code_port = (p == 0);
        next_fault_info.kind      = req[p].kind;
        next_fault_info.priv      = req[p].priv;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      code_done  <= 1'b0;
      code_ok    <= 1'b0;
      sys_done   <= 1'b0;
      sys_ok     <= 1'b0;
      sec_done   <= 1'b0;
      fault      <= 1'b0;
      fault_addr <= 32'h0000_0000;
      fault_info <= RPU_FAULT_RST;
    end else begin
      code_done  <= next_code_done;
      code_ok    <= next_code_ok;
      sys_done   <= next_sys_done;
      sys_ok     <= next_sys_ok;
      sec_done   <= next_sec_done;
      fault      <= next_fault;
      fault_addr <= next_fault_addr;
      fault_info <= next_fault_info;
    end
  end

  // checks of the observable behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_code_answer: assert property (code_req.valid |=> code_done)
    else $error("code access not answered");
  a_off_passes: assert property ((!unit_enabled && code_req.valid
      && code_req.addr <= RPU_CODE_LAST) |=> code_ok)
    else $error("disabled unit blocked an access");
  a_block_fault: assert property ((sys_done && !sys_ok) |-> fault)
    else $error("blocked access without fault");
  a_fault_addr: assert property ((code_req.valid && !allow[0])
      |=> fault && fault_addr == $past(code_req.addr))
    else $error("fault address wrong");
  a_ro_write: assert property ((unit_enabled && sys_req.valid && win_hit[1]
      && regions[win_idx[1]].ap == RPU_AP_RO && sys_req.kind == RPU_WRITE)
      |=> sys_done && !sys_ok)
    else $error("write passed a read-only region");
  a_none_denies: assert property ((unit_enabled && code_req.valid
      && win_hit[0] && regions[win_idx[0]].ap == RPU_AP_NONE)
      |=> !code_ok ##0 fault)
    else $error("no-access region let an access through");
  a_user_priv: assert property ((unit_enabled && sys_req.valid && win_hit[1]
      && regions[win_idx[1]].ap == RPU_AP_PRIV_RW && !sys_req.priv)
      |=> !sys_ok)
    else $error("user access passed a privileged region");
  a_sec_pass: assert property (sec_valid |=> sec_done)
    else $error("secondary access not passed");
  a_top_wins: assert property ((code_req.valid && hit[0][NREG-1])
      |-> win_idx[0] == 3'h7)
    else $error("lower region overrode a higher one");
  a_cfg_write: assert property (ppb_region_we
      |=> regions[$past(ppb_region_idx)] == $past(ppb_region))
    else $error("region write not taken");
  a_wrong_bus: assert property ((code_req.valid
      && code_req.addr > RPU_CODE_LAST) |=> !code_ok)
    else $error("code bus passed a system address");

endmodule : rpu_top
`default_nettype wire

// ---- verification/rpu_core_model.sv ----
// processor core model that routes accesses onto code or system bus
`timescale 1ns/10ps
`default_nettype none
module rpu_core_model
  import rpu_pkg::*;
(
  input  wire logic     core_clk,
  input  wire rpu_req_t acc,
  input  wire logic     rstn,
  output rpu_req_t      code_req,
  output rpu_req_t      sys_req
);
  // low eighth of the map (up to RPU_CODE_LAST) on the code bus, rest on the system bus;
  // an idle address keeps toggling so nobody leans on a stale value
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      code_req <= '0;
      sys_req  <= '0;
    end else begin
      code_req       <= acc;
      sys_req        <= acc;
      code_req.valid <= acc.valid && acc.addr <= RPU_CODE_LAST;
      sys_req.valid  <= acc.valid && acc.addr >= RPU_SYS_FIRST;
      if (!acc.valid) begin
        code_req.addr <= ~code_req.addr;
        sys_req.addr  <= ~sys_req.addr;
      end
    end
  end
endmodule : rpu_core_model
`default_nettype wire

// ---- verification/rpu_top_tb.sv ----
// self-checking testbench of the region protection unit
`timescale 1ns/10ps
`default_nettype none
module rpu_top_tb
  import rpu_pkg::*;
;
  logic core_clk, rstn, sec_valid, ppb_region_we, ppb_ctrl_we;
  logic ppb_enable, ppb_privdef, code_done, code_ok, sys_done, sys_ok;
  logic sec_done, fault, unit_enabled;
  logic [2:0]  ppb_region_idx;
  logic [31:0] fault_addr;
  rpu_region_t ppb_region;
  rpu_req_t    req, code_req, sys_req;
  rpu_fault_t  fault_info;
  int          num_errors, comparisons;

  rpu_core_model i_core (.core_clk(core_clk), .acc(req), .rstn(rstn),
    .code_req(code_req), .sys_req(sys_req));
  rpu_top i_dut (.core_clk(core_clk), .rstn(rstn), .code_req(code_req),
    .sys_req(sys_req), .sec_valid(sec_valid),
    .ppb_region_we(ppb_region_we), .ppb_region_idx(ppb_region_idx),
    .ppb_region(ppb_region), .ppb_ctrl_we(ppb_ctrl_we),
    .ppb_enable(ppb_enable), .ppb_privdef(ppb_privdef),
    .code_done(code_done), .code_ok(code_ok), .sys_done(sys_done),
    .sys_ok(sys_ok), .sec_done(sec_done), .fault(fault),
    .fault_addr(fault_addr), .fault_info(fault_info),
    .unit_enabled(unit_enabled));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // one access through the core model; answer lands two edges later
  task automatic acc(input logic [31:0] a, input rpu_kind_t k,
                     input logic p, input logic ok);
    logic cb;
    cb = (a <= RPU_CODE_LAST);
    req = '{valid: 1'b1, addr: a, kind: k, priv: p};
    @(posedge core_clk);
    #1 req.valid = 1'b0;
    @(posedge core_clk);
    #1 chk(32'(cb ? code_done : sys_done), 32'h1);
    chk(32'(cb ? code_ok : sys_ok), 32'(ok));
    chk(32'(fault), 32'(!ok));
    if (!ok) chk(fault_addr, a);
  endtask : acc

  task automatic wr_reg(input logic [2:0] i, input logic [31:0] b,
    input logic [4:0] s, input logic [7:0] so, input rpu_ap_t ap);
    ppb_region_idx = i;
    ppb_region = '{en: 1'b1, base: b, size: s, sub_off: so, ap: ap,
                   xn: 1'b0};
    ppb_region_we = 1'b1;
    @(posedge core_clk);
    #1 ppb_region_we = 1'b0;
    // one idle edge so a following write raises the strobe afresh
    @(posedge core_clk);
    #1;
  endtask : wr_reg

  task automatic ctl(input logic en, input logic pd);
    ppb_enable = en;
    ppb_privdef = pd;
    ppb_ctrl_we = 1'b1;
    @(posedge core_clk);
    #1 ppb_ctrl_we = 1'b0;
    chk(32'(unit_enabled), 32'(en));
  endtask : ctl

  task automatic t_reset;
    chk(32'(unit_enabled), 32'h0);
    acc(32'h4000_0000, RPU_WRITE, 1'b0, 1'b1);
    acc(32'h0000_0100, RPU_FETCH, 1'b0, 1'b1);
    $display("test reset done");
  endtask : t_reset

  // overlapping regions, subregion hole, privilege split, uncovered hole
  task automatic t_regions;
    wr_reg(3'h0, 32'h2000_0000, 5'h10, 8'h00, RPU_AP_RW);
    wr_reg(3'h1, 32'h2000_0000, 5'h0C, 8'h00, RPU_AP_RO);
    wr_reg(3'h2, 32'h0000_0000, 5'h14, 8'h00, RPU_AP_NONE);
    wr_reg(3'h7, 32'h2001_0000, 5'h10, 8'h02, RPU_AP_PRIV_RW);
    ctl(1'b1, 1'b0);
    acc(32'h2000_8000, RPU_WRITE, 1'b0, 1'b1);
    acc(32'h2000_0010, RPU_READ, 1'b0, 1'b1);
    acc(32'h2000_0010, RPU_WRITE, 1'b0, 1'b0);
    acc(32'h0000_0400, RPU_FETCH, 1'b1, 1'b0);
    chk(32'(fault_info.denied), 32'h1);
    acc(32'h2001_0040, RPU_WRITE, 1'b1, 1'b1);
    acc(32'h2001_0040, RPU_WRITE, 1'b0, 1'b0);
    acc(32'h2001_2000, RPU_READ, 1'b1, 1'b0);
    acc(32'h4000_0000, RPU_READ, 1'b1, 1'b0);
    chk(32'(fault_info.no_region), 32'h1);
    // privileged default map lets privileged code into uncovered space
    ctl(1'b1, 1'b1);
    acc(32'h4000_0000, RPU_READ, 1'b1, 1'b1);
    acc(32'h4000_0000, RPU_READ, 1'b0, 1'b0);
    $display("test regions done");
  endtask : t_regions

  // secondary core passes while the unit is enabled with its regions set
  task automatic t_sec;
    sec_valid = 1'b1;
    @(posedge core_clk);
    #1 sec_valid = 1'b0;
    chk(32'(sec_done), 32'h1);
    chk(32'(fault), 32'h0);
    $display("test secondary done");
  endtask : t_sec

  task automatic t_off;
    ctl(1'b0, 1'b0);
    acc(32'h2000_0010, RPU_WRITE, 1'b0, 1'b1);
    $display("test disable done");
  endtask : t_off

  initial begin
    rstn = 1'b0;
    req = '0;
    sec_valid = 1'b0;
    ppb_region_we = 1'b0;
    ppb_region_idx = 3'h0;
    ppb_region = '0;
    ppb_ctrl_we = 1'b0;
    ppb_enable = 1'b0;
    ppb_privdef = 1'b0;
    num_errors = 0;
    comparisons = 0;
    repeat (6) @(posedge core_clk);
    #1 rstn = 1'b1;
    t_reset();
    t_regions();
    t_sec();
    t_off();
    report_and_stop();
  end

  // the whole run needs well under a few hundred cycles
  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end
endmodule : rpu_top_tb
`default_nettype wire
